/* File: arith_unit_ctrl.v */
// Purpose: control decode for the auxiliary address adder and the main arithmetic unit
// Assumes: every input comes from processor logic on clk; phases are one-cycle pulses
// Notes: every output is registered, so each control shows one cycle after its cause
//
// How it works
// - plus-one request low on first half with increment, or both loader states
// - loader stores each byte at the address one above the previous byte
// - plus-four request low when a test fails in the second fetch state
// - holding register gated into adder on compare-cursor or second refresh state
// - holding register strobed on register clear, T17, and T7 with refresh qualifier
// - separate active-low success and failure from ANDed exclusive-or terms
// - io test qualifier needs io decode, memory data bit 8 and bit 9 high
// - accumulator gated to main unit on add during execute, or add-immediate
// - true memory data byte to bus on immediates except subtract-immediate, or and/or/add/load in execute
// - complemented byte to bus on compare-jump, subtract-immediate, subtract/compare in execute
// - bus bits 6 and 7 forced to zero on line or char register transfer
// - io data-in to bus while byte wait low, or on acknowledged io read or write
// - controller raises boot; on a ready character enter byte wait and take it
// - flag register strobe at T11 with condition-set qualifier, T7 for inc/dec ops, T16 cursor compare in execute, clear
// - adder result routed to flag register for compare-cursor and inc/dec ops
// - low four data bits shift into accumulator high nibble on either low shift decode
// - compare-cursor compares memory data with marker, result modifies adder input
// - execute split into halves by timing phase-4 bit, each high while active
`timescale 1ns/1ps
`default_nettype none
`include "arith_unit_ctrl_regs.vh"

module arith_unit_ctrl #(
  parameter ADDR_W = `ADDR_W,
  parameter BYTE_W = `BYTE_W,
  parameter LINE_W = `LINE_W
) (
  input wire clk,
  input wire rst,

  input wire exec_state,
  input wire timing_phase4,
  input wire increment_op_decode,
  input wire inc2_op_decode,
  input wire dec_op_decode,

  input wire loader_state_a,
  input wire loader_state_b,
  input wire second_fetch_state,
  input wire compare_cursor_qualifier,
  input wire refresh_second_state,
  input wire register_clear,
  input wire refresh_qualifier,

  input wire t7,
  input wire t11,
  input wire t16,
  input wire t17,

  input wire io_op_decode,
  input wire [ADDR_W-1:0] memory_data_reg,
  input wire jump_cond_op,
  input wire compare_jump_op,
  input wire [`TEST_TERMS-1:0] test_cond_a,
  input wire [`TEST_TERMS-1:0] test_cond_b,

  input wire add_op_decode,
  input wire add_immediate_decode,
  input wire immediate_op,
  input wire subtract_immediate_decode,
  input wire and_op,
  input wire or_op,
  input wire load_op,
  input wire subtract_op,
  input wire compare_op,

  input wire line_to_acc,
  input wire char_to_acc,
  input wire io_acknowledge,
  input wire condition_set_qualifier,
  input wire generic_nibble_shift_decode_n,
  input wire loader_shift_n,

  input wire boot_line,
  input wire char_available,
  input wire [ADDR_W-1:0] loader_base,
  input wire [BYTE_W-1:0] accumulator,
  input wire [BYTE_W-1:0] io_data_in,
  input wire [LINE_W-1:0] line_reg,
  input wire [LINE_W-1:0] char_reg,

  output reg run_phase_first_half_q,
  output reg run_phase_second_half_q,
  output reg plus_one_n_q,
  output reg plus_four_n_q,
  output reg hold_to_adder_q,
  output reg hold_strobe_q,

  output reg test_success_n_q,
  output reg test_fail_n_q,
  output reg io_test_qualifier_q,
  output reg acc_to_alu_q,
  output reg mdr_true_to_bus_q,
  output reg mdr_comp_to_bus_q,
  output reg bus_clear_hi_q,
  output reg io_to_bus_q,
  output reg csr_strobe_q,
  output reg adder_to_csr_q,
  output reg nibble_shift_q,
  output reg cursor_match_q,
  output reg loader_byte_wait_n_q,
  output reg loader_active_q,
  output reg [ADDR_W-1:0] loader_addr_q,
  output reg [BYTE_W-1:0] main_arith_bus_q,
  output reg [BYTE_W-1:0] acc_shift_value_q
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // line and char registers are narrower than the bus; the pad is always zero
  function [BYTE_W-1:0] widen_line;
    input [LINE_W-1:0] v;
    begin
      widen_line = {`PAD_HI, v};
    end
  endfunction

  // ****************************************************************
  // execute halves
  // ****************************************************************
  wire run_first_d;
  wire run_second_d;
  assign run_first_d = exec_state & ~timing_phase4;
  assign run_second_d = exec_state & timing_phase4;

  // ****************************************************************
  // test evaluation
  // ****************************************************************
  wire io_test_d;
  wire success_n_d;
  wire fail_n_d;
  wire [`TEST_TERMS-1:0] test_qual;

  assign io_test_d = io_op_decode & memory_data_reg[`MEM_TEST_BIT] &
    memory_data_reg[`MEM_KIND_BIT];
  assign test_qual = {compare_jump_op, io_test_d, compare_op, jump_cond_op};

  test_result_eval #(
    .N(`TEST_TERMS)
  ) u_test_eval (
    .cond_a(test_cond_a),
    .cond_b(test_cond_b),
    .qual(test_qual),
    .success_n(success_n_d),
    .fail_n(fail_n_d)
  );

  // ****************************************************************
  // auxiliary adder controls
  // ****************************************************************
  wire plus_one_n_d;
  wire plus_four_n_d;
  wire hold_to_adder_d;
  wire hold_strobe_d;
  wire incdec_op;

  assign incdec_op = increment_op_decode | inc2_op_decode | dec_op_decode;
  // and-or-invert: low when either pair is fully high
  assign plus_one_n_d = ~((run_first_d & increment_op_decode) |
    (loader_state_a & loader_state_b));
  // the fail term is the live decode, so the skip shows one cycle after the state that tested, together with the test result
  assign plus_four_n_d = ~(~fail_n_d & second_fetch_state);
  assign hold_to_adder_d = compare_cursor_qualifier | refresh_second_state;
  assign hold_strobe_d = register_clear | t17 | (t7 & refresh_qualifier);

  // ****************************************************************
  // compare-cursor modifier
  // ****************************************************************
  wire [ADDR_W-1:0] marker_pos;
  assign marker_pos = {line_reg, char_reg};

  // ****************************************************************
  // main arithmetic unit controls
  // ****************************************************************
  wire acc_to_alu_d;
  wire mdr_true_d;
  wire mdr_comp_d;
  wire clear_hi_d;
  wire io_rw_ack;
  wire io_to_bus_d;
  wire csr_strobe_d;
  wire adder_to_csr_d;
  wire nibble_shift_d;

  assign acc_to_alu_d = (add_op_decode & exec_state) | add_immediate_decode;
  assign mdr_true_d = (immediate_op & ~subtract_immediate_decode) |
    ((and_op | or_op | add_op_decode | load_op) & exec_state);
  assign mdr_comp_d = compare_jump_op | subtract_immediate_decode |
    ((subtract_op | compare_op) & exec_state);
  assign clear_hi_d = line_to_acc | char_to_acc;
  // bit 9 low marks the read and write forms of the io instruction
  assign io_rw_ack = io_op_decode & ~memory_data_reg[`MEM_KIND_BIT] & io_acknowledge;
  assign io_to_bus_d = ~loader_byte_wait_n_q | io_rw_ack;
  assign csr_strobe_d = (t11 & condition_set_qualifier) | (t7 & incdec_op) |
    (t16 & compare_cursor_qualifier & exec_state) | register_clear;
  assign adder_to_csr_d = compare_cursor_qualifier | incdec_op;
  assign nibble_shift_d = ~generic_nibble_shift_decode_n | ~loader_shift_n;

  // ****************************************************************
  // bus source mux
  // ****************************************************************
  // io has priority so a loader byte is never overrun by a stale memory select
  reg [BYTE_W-1:0] bus_d;
  always @* begin
    bus_d = `BYTE_ZERO;
    if (io_to_bus_d) begin
      bus_d = io_data_in;
    end else if (line_to_acc) begin
      bus_d = widen_line(line_reg);
    end else if (char_to_acc) begin
      bus_d = widen_line(char_reg);
    end else if (mdr_true_d) begin
      bus_d = memory_data_reg[BYTE_W-1:0];
    end else if (mdr_comp_d) begin
      bus_d = ~memory_data_reg[BYTE_W-1:0];
    end
    if (clear_hi_d) begin
      bus_d[BYTE_W-1:`BUS_CLEAR_LO] = `PAD_HI;
    end
  end

  // ****************************************************************
  // loader sequencing
  // ****************************************************************
  // one byte wait per character; char_available must drop before the next one counts
  reg char_seen_q;
  wire take_char;
  assign take_char = loader_active_q & char_available & ~char_seen_q;

  always @(posedge clk) begin
    if (rst) begin
      loader_active_q <= 1'b0;
      loader_byte_wait_n_q <= `IDLE_LOW_ACTIVE;
      char_seen_q <= 1'b0;
      loader_addr_q <= `ADDR_ZERO;
    end else begin
      loader_active_q <= boot_line;
      loader_byte_wait_n_q <= ~take_char;
      char_seen_q <= loader_active_q & char_available;
      if (boot_line & ~loader_active_q) begin
        loader_addr_q <= loader_base;
      end else if (~loader_byte_wait_n_q) begin
        loader_addr_q <= loader_addr_q + `LOADER_STEP;
      end
    end
  end

  // ****************************************************************
  // output registers: execute halves and adder controls
  // ****************************************************************
  // registering costs a cycle but gives every decode a full cycle to settle
  always @(posedge clk) begin
    if (rst) begin
      run_phase_first_half_q <= `IDLE_HIGH_ACTIVE;
      run_phase_second_half_q <= `IDLE_HIGH_ACTIVE;
      plus_one_n_q <= `IDLE_LOW_ACTIVE;
      plus_four_n_q <= `IDLE_LOW_ACTIVE;
      hold_to_adder_q <= `IDLE_HIGH_ACTIVE;
      hold_strobe_q <= `IDLE_HIGH_ACTIVE;
    end else begin
      run_phase_first_half_q <= run_first_d;
      run_phase_second_half_q <= run_second_d;
      plus_one_n_q <= plus_one_n_d;
      plus_four_n_q <= plus_four_n_d;
      hold_to_adder_q <= hold_to_adder_d;
      hold_strobe_q <= hold_strobe_d;
    end
  end

  // ****************************************************************
  // output registers: test results
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      test_success_n_q <= `IDLE_LOW_ACTIVE;
      test_fail_n_q <= `IDLE_LOW_ACTIVE;
      io_test_qualifier_q <= `IDLE_HIGH_ACTIVE;
      cursor_match_q <= `IDLE_HIGH_ACTIVE;
    end else begin
      test_success_n_q <= success_n_d;
      test_fail_n_q <= fail_n_d;
      io_test_qualifier_q <= io_test_d;
      // match is held between compares so the adder sees a stable modifier
      if (compare_cursor_qualifier) begin
        cursor_match_q <= (memory_data_reg == marker_pos);
      end
    end
  end

  // ****************************************************************
  // output registers: main unit selects
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      acc_to_alu_q <= `IDLE_HIGH_ACTIVE;
      mdr_true_to_bus_q <= `IDLE_HIGH_ACTIVE;
      mdr_comp_to_bus_q <= `IDLE_HIGH_ACTIVE;
      bus_clear_hi_q <= `IDLE_HIGH_ACTIVE;
      io_to_bus_q <= `IDLE_HIGH_ACTIVE;
      csr_strobe_q <= `IDLE_HIGH_ACTIVE;
      adder_to_csr_q <= `IDLE_HIGH_ACTIVE;
      nibble_shift_q <= `IDLE_HIGH_ACTIVE;
    end else begin
      acc_to_alu_q <= acc_to_alu_d;
      mdr_true_to_bus_q <= mdr_true_d;
      mdr_comp_to_bus_q <= mdr_comp_d;
      bus_clear_hi_q <= clear_hi_d;
      io_to_bus_q <= io_to_bus_d;
      csr_strobe_q <= csr_strobe_d;
      adder_to_csr_q <= adder_to_csr_d;
      nibble_shift_q <= nibble_shift_d;
    end
  end

  // ****************************************************************
  // output registers: bus values
  // ****************************************************************
  always @(posedge clk) begin
    if (rst) begin
      main_arith_bus_q <= `BYTE_ZERO;
      acc_shift_value_q <= `BYTE_ZERO;
    end else begin
      main_arith_bus_q <= bus_d;
      if (nibble_shift_d) begin
        acc_shift_value_q <= {bus_d[`NIBBLE_W-1:0],
          accumulator[`NIBBLE_W-1:0]};
      end else begin
        acc_shift_value_q <= accumulator;
      end
    end
  end

endmodule

`default_nettype wire

/* File: arith_unit_ctrl_checker.sv */
// Purpose: assertion checker for the arith unit control outputs
// Assumes: bound to arith_unit_ctrl, one clock domain
// Notes: every control lags its cause by one edge
`timescale 1ns/1ps
`default_nettype none
module arith_unit_ctrl_checker #(
  parameter ADDR_W = 12
) (
  input wire logic clk, rst, exec_state, timing_phase4, increment_op_decode, inc2_op_decode,
  input wire logic dec_op_decode, loader_state_a, loader_state_b, second_fetch_state, t7, t11,
  input wire logic compare_cursor_qualifier, register_clear, refresh_qualifier, t16, t17,
  input wire logic io_op_decode, jump_cond_op, compare_jump_op, compare_op, add_op_decode,
  input wire logic add_immediate_decode, line_to_acc, char_to_acc, condition_set_qualifier,
  input wire logic [ADDR_W-1:0] memory_data_reg, loader_addr_q,
  input wire logic [3:0] test_cond_a, test_cond_b,
  input wire logic [7:0] main_arith_bus_q,
  input wire logic run_phase_first_half_q, run_phase_second_half_q, plus_one_n_q,
  input wire logic plus_four_n_q, hold_strobe_q, test_success_n_q, test_fail_n_q,
  input wire logic io_test_qualifier_q, acc_to_alu_q, bus_clear_hi_q, io_to_bus_q,
  input wire logic csr_strobe_q, adder_to_csr_q, loader_byte_wait_n_q
);
  // ****************************************************************
  // decode terms
  // ****************************************************************
  logic [3:0] diff, qual;
  logic inc_any;
  assign diff = test_cond_a ^ test_cond_b;
  assign qual = {compare_jump_op, io_op_decode & memory_data_reg[8] & memory_data_reg[9],
    compare_op, jump_cond_op};
  assign inc_any = increment_op_decode | inc2_op_decode | dec_op_decode;
  // outputs are flops, so every check looks one edge after its cause
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_plus_one;
    1'b1 |=> plus_one_n_q == !$past((exec_state && !timing_phase4 && increment_op_decode)
      || (loader_state_a && loader_state_b));
  endproperty
  a_plus_one: assert property (p_plus_one) else $error("plus one request wrong");
  property p_plus_four;
    second_fetch_state && |(~diff & qual) |=> !plus_four_n_q;
  endproperty
  a_plus_four: assert property (p_plus_four) else $error("plus four missing");
  property p_test;
    1'b1 |=> {test_success_n_q, test_fail_n_q} == {!$past(|(diff & qual)),
      !$past(|(~diff & qual))};
  endproperty
  a_test: assert property (p_test) else $error("test result wrong");
  property p_io_test;
    qual[2] |-> ##1 io_test_qualifier_q;
  endproperty
  a_io_test: assert property (p_io_test) else $error("io test qualifier missing");
  property p_aar_strobe;
    1'b1 |=> hold_strobe_q == $past(register_clear || t17 || (t7 && refresh_qualifier));
  endproperty
  a_aar_strobe: assert property (p_aar_strobe) else $error("holding strobe wrong");
  property p_csr_strobe;
    1'b1 |=> csr_strobe_q == $past(register_clear || (t11 && condition_set_qualifier)
      || (t7 && inc_any) || (t16 && compare_cursor_qualifier && exec_state));
  endproperty
  a_csr_strobe: assert property (p_csr_strobe) else $error("flag strobe wrong");
  property p_adder_csr;
    compare_cursor_qualifier || inc_any |=> adder_to_csr_q;
  endproperty
  a_adder_csr: assert property (p_adder_csr) else $error("adder to flags missing");
  property p_acc;
    (add_op_decode && exec_state) || add_immediate_decode |=> acc_to_alu_q;
  endproperty
  a_acc: assert property (p_acc) else $error("accumulator gate missing");
  property p_bus_hi;
    line_to_acc || char_to_acc |=> bus_clear_hi_q && main_arith_bus_q[7:6] == 2'h0;
  endproperty
  a_bus_hi: assert property (p_bus_hi) else $error("bus top bits not cleared");
  property p_byte_wait;
    $fell(loader_byte_wait_n_q) |=> io_to_bus_q && loader_byte_wait_n_q;
  endproperty
  a_byte_wait: assert property (p_byte_wait) else $error("byte wait take wrong");
  property p_addr_step;
    $fell(loader_byte_wait_n_q) |=> loader_addr_q == $past(loader_addr_q) + 1'b1;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("loader address step");
  property p_halves;
    exec_state |=> run_phase_first_half_q != run_phase_second_half_q;
  endproperty
  a_halves: assert property (p_halves) else $error("execute halves wrong");
endmodule

bind arith_unit_ctrl arith_unit_ctrl_checker #(.ADDR_W(ADDR_W)) u_arith_unit_ctrl_checker (.*);
`default_nettype wire

/* File: arith_unit_ctrl_regs.vh */
// Purpose: shared widths, reset levels and increment amounts for the arith unit control
// Assumes: included by the arith unit control design files only
// Notes: definitions only, no logic
`ifndef ARITH_UNIT_CTRL_REGS_VH
`define ARITH_UNIT_CTRL_REGS_VH

// ****************************************************************
// widths
// ****************************************************************
`define ADDR_W 12
`define BYTE_W 8
`define LINE_W 6
`define NIBBLE_W 4
`define TEST_TERMS 4

// ****************************************************************
// field positions in the memory data word and on the main arithmetic bus
// ****************************************************************
`define MEM_TEST_BIT 8
`define MEM_KIND_BIT 9
`define BUS_CLEAR_LO 6

// ****************************************************************
// increments and reset levels
// ****************************************************************
`define LOADER_STEP 12'h001
`define ADDR_ZERO 12'h000
`define BYTE_ZERO 8'h00
`define PAD_HI 2'h0
`define IDLE_LOW_ACTIVE 1'h1
`define IDLE_HIGH_ACTIVE 1'h0

`endif

/* File: loader_ctrl_model.sv */
// Purpose: boot controller model feeding characters to the block
// Assumes: go is a one-cycle request from the bench
// Notes: data line shows the inverse once its hold time is over
`timescale 1ns/1ps
`default_nettype none
module loader_ctrl_model #(
  parameter logic [11:0] BASE = 12'h1f0
) (
  input wire logic clk,
  input wire logic go,
  output logic boot_line,
  output logic char_available,
  output logic [7:0] io_data_in,
  output logic [11:0] loader_base
);
  initial begin
    {boot_line, char_available, io_data_in} = '0;
    loader_base = BASE;
    forever begin
      @(posedge clk);
      if (go) begin
        boot_line <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 3; i++) begin
          @(posedge clk);
          char_available <= 1'b1;
          io_data_in <= 8'h5a + 8'(i);
          @(posedge clk);
          char_available <= 1'b0;
          // hold the byte until the block has routed it to the bus
          repeat (2) @(posedge clk);
          io_data_in <= ~io_data_in;
        end
        boot_line <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test_arith_unit_ctrl.sv */
// Purpose: self-checking bench for arith_unit_ctrl
// Assumes: loader_ctrl_model plays the boot controller
// Notes: outputs are sampled 1 ns after the edge that registers them
`timescale 1ns/1ps
`default_nettype none
module test_arith_unit_ctrl;
  localparam logic [11:0] LBASE = 12'h1f0;
  logic clk, rst, exec_state, timing_phase4, increment_op_decode, inc2_op_decode, dec_op_decode;
  logic loader_state_a, loader_state_b, second_fetch_state, compare_cursor_qualifier, go;
  logic refresh_second_state, register_clear, refresh_qualifier, t7, t11, t16, t17, io_op_decode;
  logic jump_cond_op, compare_jump_op, add_op_decode, add_immediate_decode, immediate_op;
  logic subtract_immediate_decode, and_op, or_op, load_op, subtract_op, compare_op, line_to_acc;
  logic char_to_acc, io_acknowledge, condition_set_qualifier, generic_nibble_shift_decode_n;
  logic loader_shift_n, boot_line, char_available, loader_active_q, cursor_match_q;
  logic [11:0] memory_data_reg, loader_base, loader_addr_q;
  logic [3:0] test_cond_a, test_cond_b;
  logic [7:0] accumulator, io_data_in, main_arith_bus_q, acc_shift_value_q;
  logic [5:0] line_reg, char_reg;
  logic run_phase_first_half_q, run_phase_second_half_q, plus_one_n_q, plus_four_n_q;
  logic hold_to_adder_q, hold_strobe_q, test_success_n_q, test_fail_n_q, io_test_qualifier_q;
  logic acc_to_alu_q, mdr_true_to_bus_q, mdr_comp_to_bus_q, bus_clear_hi_q, io_to_bus_q;
  logic csr_strobe_q, adder_to_csr_q, nibble_shift_q, loader_byte_wait_n_q;
  int miscompares, n_checks;

  arith_unit_ctrl u_arith_unit_ctrl (.*);
  loader_ctrl_model #(.BASE(LBASE)) u_loader_ctrl_model (.clk(clk), .go(go),
    .boot_line(boot_line), .char_available(char_available), .io_data_in(io_data_in),
    .loader_base(loader_base));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task chk_bit(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: bit %b expected %b", $time, g, e);
    end
  endtask
  task chk_vec(input logic [11:0] g, input logic [11:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: value %h expected %h", $time, g, e);
    end
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  task idle;
    {exec_state, timing_phase4, increment_op_decode, inc2_op_decode, dec_op_decode, go} <= '0;
    {loader_state_a, loader_state_b, second_fetch_state, compare_cursor_qualifier} <= '0;
    {refresh_second_state, register_clear, refresh_qualifier, t7, t11, t16, t17} <= '0;
    {io_op_decode, jump_cond_op, compare_jump_op, add_op_decode, add_immediate_decode} <= '0;
    {immediate_op, subtract_immediate_decode, and_op, or_op, load_op, subtract_op} <= '0;
    {compare_op, line_to_acc, char_to_acc, io_acknowledge, condition_set_qualifier} <= '0;
    {memory_data_reg, test_cond_a, test_cond_b, accumulator, line_reg, char_reg} <= '0;
    {generic_nibble_shift_decode_n, loader_shift_n} <= 2'h3;
  endtask
  task finish_test;
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task s_phase;
    @(posedge clk);
    {exec_state, increment_op_decode} <= 2'h3;
    tick;
    chk_bit(plus_one_n_q, 1'b0);
    chk_bit(run_phase_first_half_q, 1'b1);
    @(posedge clk);
    timing_phase4 <= 1'b1;
    tick;
    chk_bit(plus_one_n_q, 1'b1);
    chk_bit(run_phase_second_half_q, 1'b1);
    @(posedge clk);
    {loader_state_a, loader_state_b} <= 2'h3;
    tick;
    chk_bit(plus_one_n_q, 1'b0);
    @(posedge clk);
    idle;
  endtask
  task s_test;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {compare_jump_op, io_op_decode, compare_op, jump_cond_op} <= 4'h1 << i[1:0];
      {second_fetch_state, memory_data_reg, test_cond_b} <= {1'b1, 12'h300, {4{i[2]}}};
      tick;
      chk_bit(test_success_n_q, !i[2]);
      chk_bit(test_fail_n_q, i[2]);
      chk_bit(plus_four_n_q, i[2]);
      chk_bit(io_test_qualifier_q, i[1:0] == 2'h2);
    end
    @(posedge clk);
    idle;
  endtask
  task s_bus;
    logic [3:0] pat [4];
    pat = '{4'h8, 4'hc, 4'h2, 4'h1};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {immediate_op, subtract_immediate_decode, and_op, subtract_op} <= pat[i];
      {exec_state, memory_data_reg} <= {1'b1, 12'h0a5};
      tick;
      chk_bit(mdr_true_to_bus_q, !i[0]);
      chk_bit(mdr_comp_to_bus_q, i[0]);
      chk_vec(main_arith_bus_q, i[0] ? 12'h05a : 12'h0a5);
    end
    @(posedge clk);
    {line_to_acc, line_reg} <= {1'b1, 6'h3f};
    tick;
    chk_vec(main_arith_bus_q, 12'h03f);
    @(posedge clk);
    {line_to_acc, char_to_acc, char_reg} <= {2'h1, 6'h2a};
    tick;
    chk_vec(main_arith_bus_q, 12'h02a);
    chk_bit(bus_clear_hi_q, 1'b1);
    @(posedge clk);
    idle;
  endtask
  task s_strobe;
    logic [15:0] tab [11];
    tab = '{16'h1008, 16'h8000, 16'h8808, 16'h4404, 16'h4000, 16'h2307, 16'h2203,
      16'h8086, 16'h8046, 16'h8026, 16'h0011};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      {t7, t11, t16, t17, refresh_qualifier, condition_set_qualifier, compare_cursor_qualifier,
        exec_state, increment_op_decode, inc2_op_decode, dec_op_decode,
        refresh_second_state} <= tab[i][15:4];
      tick;
      chk_bit(hold_strobe_q, tab[i][3]);
      chk_bit(csr_strobe_q, tab[i][2]);
      chk_bit(adder_to_csr_q, tab[i][1]);
      chk_bit(hold_to_adder_q, tab[i][0]);
    end
    @(posedge clk);
    idle;
  endtask
  task s_misc;
    @(posedge clk);
    {register_clear, add_immediate_decode, generic_nibble_shift_decode_n} <= 3'h6;
    {io_op_decode, io_acknowledge, memory_data_reg} <= {2'h3, 12'h100};
    compare_cursor_qualifier <= 1'b1;
    tick;
    chk_bit(hold_strobe_q, 1'b1);
    chk_bit(csr_strobe_q, 1'b1);
    chk_bit(acc_to_alu_q, 1'b1);
    chk_bit(nibble_shift_q, 1'b1);
    chk_bit(io_to_bus_q, 1'b1);
    chk_bit(io_test_qualifier_q, 1'b0);
    chk_bit(cursor_match_q, 1'b0);
    @(posedge clk);
    {register_clear, add_immediate_decode, io_op_decode} <= 3'h0;
    {generic_nibble_shift_decode_n, loader_shift_n, add_op_decode, exec_state} <= 4'hb;
    {accumulator, memory_data_reg, line_reg, char_reg} <= {8'h3c, 12'h0a7, 6'h02, 6'h27};
    tick;
    chk_bit(nibble_shift_q, 1'b1);
    chk_vec(acc_shift_value_q, 12'h07c);
    chk_bit(cursor_match_q, 1'b1);
    chk_bit(acc_to_alu_q, 1'b1);
    chk_bit(io_to_bus_q, 1'b0);
    @(posedge clk);
    idle;
    tick;
    chk_bit(nibble_shift_q, 1'b0);
    chk_bit(cursor_match_q, 1'b1);
  endtask
  task s_loader;
    int n;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      n = 0;
      // bounded wait so a missing byte wait cannot hang the run
      do begin
        tick;
        n++;
      end while (loader_byte_wait_n_q !== 1'b0 && n < 20);
      chk_vec(loader_addr_q, 12'(LBASE + i));
      chk_bit(loader_active_q, 1'b1);
      tick;
      chk_bit(io_to_bus_q, 1'b1);
      chk_vec(main_arith_bus_q, 12'(8'h5a + i));
      chk_vec(loader_addr_q, 12'(LBASE + i + 1));
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst <= 1'b1;
    idle;
    repeat (5) @(posedge clk);
    #1;
    chk_bit(plus_one_n_q, 1'b1);
    chk_vec(loader_addr_q, 12'h000);
    @(posedge clk);
    rst <= 1'b0;
    s_phase;
    s_test;
    s_bus;
    s_strobe;
    s_misc;
    s_loader;
    finish_test;
  end
  initial begin
    #200000;
    miscompares++;
    finish_test;
  end
endmodule
`default_nettype wire

/* File: test_result_eval.v */
// Purpose: forms the active-low test success and test failure terms
// Assumes: all inputs come from logic on the same clock
// Notes: purely combinational; the parent registers the results
`timescale 1ns/1ps
`default_nettype none

module test_result_eval #(
  parameter N = 4
) (
  input wire [N-1:0] cond_a,
  input wire [N-1:0] cond_b,
  input wire [N-1:0] qual,
  output wire success_n,
  output wire fail_n
);

  // ****************************************************************
  // exclusive-or stage, one gate per condition pair
  // ****************************************************************
  wire [N-1:0] differ;
  wire [N-1:0] pass_term;
  wire [N-1:0] fail_term;

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_term
      assign differ[i] = cond_a[i] ^ cond_b[i];
      assign pass_term[i] = differ[i] & qual[i];
      assign fail_term[i] = ~differ[i] & qual[i];
    end
  endgenerate

  // ****************************************************************
  // and-or-invert stage
  // ****************************************************************
  // a qualifier that is low contributes to neither side; with every qualifier low both stay high
  assign success_n = ~(|pass_term);
  assign fail_n = ~(|fail_term);

endmodule

`default_nettype wire
